// ==== rtl/csop_output_path.sv ====
// The Avalon-MM interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/100ps
// Functional notes
// RULE1 - optional chroma filter halves chroma rate for 4:2:2 output
// RULE2 - accepts RGB 8, 4:4:4 8, and 4:2:2 at 8/10/12 bits
// RULE3 - output modes 4:4:4, 4:2:2 8/10/12, dual 8-bit DDR, 12-bit DDR
// RULE4 - three identical rows, each summing three weighted inputs
// RULE5 - coefficients and offsets held as 13-bit signed values
// RULE6 - matrix accepts one pixel every clock; the code drops in_ready while a finished word waits on a busy crossing
// RULE7 - red/Cr, green/Y, blue/Cb feed first, second, third inputs
// RULE8 - coefficient value equals stored integer over 4096
// RULE9 - each row adds its own offset
// RULE10 - one shift setting scales all coefficients and offsets
// RULE11 - rows two and three have their own coefficient sets
// RULE12 - output clock rises midway between data changes; in 4:4:4 and 4:2:2 modes it rises one cycle into a four-cycle word
// RULE13 - first six output words are flush words, not valid
// RULE14 - DDR modes put chroma on rising, luma on falling half
// RULE15 - matrix results saturate instead of wrapping
module csop_output_path #(
   parameter int ADDR_W = 8
)(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic link_clk,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire csop_pkg::csop_pix_type in_pix,
   input wire logic in_valid,
   output logic in_ready,
   output csop_pkg::csop_out_type out_data,
   output logic out_clk,
   output logic out_de
);
   import csop_pkg::*;

   generate
      if (ADDR_W < 8)
         $error("ADDR_W must be at least 8");
   endgenerate

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
      input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (be[i])
            r[i*8 +: 8] = wd[i*8 +: 8];
      return r;
   endfunction

   function automatic logic [SAMPLE_W-1:0] width_mask(input logic [1:0] width);
      logic [SAMPLE_W-1:0] m;
      case (width)
         WID_8: m = 12'hFF0;
         WID_10: m = 12'hFFC;
         default: m = 12'hFFF;
      endcase
      return m;
   endfunction

   function automatic csop_out_type pack_out(input csop_word_type w, input logic [1:0] mode,
      input logic [1:0] width, input logic fall);
      csop_out_type o;
      logic [SAMPLE_W-1:0] m;
      m = width_mask(width);
      o = '0;
      unique case (mode)
         OUT_444:
            o = {w.c0[11:4], w.c1[11:4], w.c2[11:4]};
         OUT_422:
            if (width == WID_8)
               o = {w.c0[11:4], w.c1[11:4], 8'h00};
            else
               o = {w.c0 & m, w.c1 & m};
         // RULE14 - chroma rising half, luma falling half
         OUT_DUAL8_DDR:
            o.blue = fall ? w.c1[11:4] : w.c0[11:4];
         OUT_422_12_DDR:
            o = {12'h000, fall ? w.c1 : w.c0};
      endcase
      return o;
   endfunction

   // ************************************************************
   // register file
   // ************************************************************
   logic [31:0] ctrl, next_ctrl, rdata, next_rdata, coef_wr;
   // RULE5 - 13-bit signed coefficient and offset storage
   logic [ROWS*TERMS-1:0][COEF_W-1:0] coef, next_coef;
   logic ack, next_ack, access, is_ctrl, is_status, is_coef, busy;
   logic [3:0] coef_idx;
   logic [15:0] word_count, next_word_count;

   assign access = avs_read | avs_write;
   assign avs_waitrequest = access & ~ack;
   assign avs_readdata = rdata;
   assign is_ctrl = avs_address == ADDR_W'(REG_CTRL);
   assign is_status = avs_address == ADDR_W'(REG_STATUS);
   assign is_coef = (avs_address >= ADDR_W'(REG_COEF_BASE))
      && (avs_address <= ADDR_W'(REG_COEF_LAST)) && (avs_address[1:0] == 2'h0);
   assign coef_idx = avs_address[5:2] - REG_COEF_BASE[5:2];
   assign coef_wr = merge({19'h0, coef[coef_idx]}, avs_writedata, avs_byteenable);

   always_comb
   begin
      next_ack = access & ~ack;
      next_ctrl = ctrl;
      next_coef = coef;
      next_rdata = rdata;
      if (access & ~ack & avs_read)
      begin
         if (is_ctrl)
            next_rdata = ctrl;
         else if (is_status)
            next_rdata = {15'h0, busy, word_count};
         else if (is_coef)
            next_rdata = {19'h0, coef[coef_idx]};
         else
            next_rdata = 32'h0;
      end
      if (ack & avs_write)
      begin
         if (is_ctrl)
            next_ctrl = merge(ctrl, avs_writedata, avs_byteenable) & CTRL_MASK;
         // RULE11 - each row owns its own terms
         if (is_coef)
            next_coef[coef_idx] = coef_wr[COEF_W-1:0];
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         ack <= 1'b0;
         ctrl <= CTRL_RESET;
         coef <= COEF_RESET;
         rdata <= 32'h0;
      end
      else
      begin
         ack <= next_ack;
         ctrl <= next_ctrl;
         coef <= next_coef;
         rdata <= next_rdata;
      end
   end

   logic [1:0] in_fmt, in_width, out_mode, out_width;
   logic [SHIFT_W-1:0] scale_shift;
   logic filt_en;

   assign in_fmt = ctrl[CTRL_IN_FMT_LSB +: 2];
   assign in_width = ctrl[CTRL_IN_W_LSB +: 2];
   assign out_mode = ctrl[CTRL_OUT_MODE_LSB +: 2];
   assign out_width = ctrl[CTRL_OUT_W_LSB +: 2];
   assign scale_shift = ctrl[CTRL_SHIFT_LSB +: SHIFT_W];
   assign filt_en = ctrl[CTRL_FILT_BIT];

   // ************************************************************
   // pixel pipeline
   // ************************************************************
   csop_pix_type s0, next_s0;
   csop_word_type s4, next_s4, xfer_word, next_xfer_word;
   logic [3:0] v, next_v;
   logic v4, next_v4, advance, ph_in, next_ph_in, ph_out, next_ph_out;
   logic xfer_req, next_xfer_req, ack_s1, ack_s2;
   logic [SAMPLE_W-1:0] msk, r_m, g_m, b_m, cb_hold, next_cb_hold, cr_hold, next_cr_hold;
   logic [SAMPLE_W-1:0] cb_prev, next_cb_prev, cr_prev, next_cr_prev;
   logic [SAMPLE_W-1:0] chroma, prev, avg;
   logic [ROWS-1:0][SAMPLE_W-1:0] rowy;

   assign msk = width_mask(in_width);
   assign r_m = in_pix.red & msk;
   assign g_m = in_pix.green & msk;
   assign b_m = in_pix.blue & msk;
   assign busy = xfer_req != ack_s2;
   // RULE6 - only a busy crossing stalls the stream
   assign advance = ~v4 | ~busy;
   assign in_ready = advance;
   assign chroma = ph_out ? rowy[0] : rowy[2];
   assign prev = ph_out ? cr_prev : cb_prev;
   // RULE1 - two-tap chroma average
   assign avg = 12'((13'(chroma) + 13'(prev) + 13'h1) >> 1);

   genvar gr;
   generate
      for (gr = 0; gr < ROWS; gr++)
      begin : g_row
         // RULE9 - per-row offset in the fourth term
         csop_matrix_row u_row (
            .ref_clk(ref_clk),
            .reset(reset),
            .advance(advance),
            .pix(s0),
            .coef(coef[gr*TERMS +: TERMS]),
            .shift(scale_shift),
            .result(rowy[gr])
         );
      end
   endgenerate

   always_comb
   begin
      next_s0 = s0;
      next_s4 = s4;
      next_v = v;
      next_v4 = v4;
      next_ph_in = ph_in;
      next_ph_out = ph_out;
      next_cb_hold = cb_hold;
      next_cr_hold = cr_hold;
      next_cb_prev = cb_prev;
      next_cr_prev = cr_prev;
      next_xfer_word = xfer_word;
      next_xfer_req = xfer_req;
      next_word_count = word_count;
      if (advance)
      begin
         next_v = {v[2:0], in_valid};
         next_v4 = v[3];
         if (in_valid)
         begin
            // RULE7 - red/Cr, green/Y, blue/Cb routing
            next_s0 = {r_m, g_m, b_m};
            // RULE2 - 4:2:2 input carries alternating Cb, Cr on red
            if (in_fmt == IN_YCC422)
            begin
               next_ph_in = ~ph_in;
               if (~ph_in)
               begin
                  next_cb_hold = r_m;
                  next_s0.blue = r_m;
                  next_s0.red = cr_hold;
               end
               else
               begin
                  next_cr_hold = r_m;
                  next_s0.blue = cb_hold;
               end
            end
         end
         if (v[3])
         begin
            // RULE3 - word layout per output mode
            if (out_mode == OUT_444)
               next_s4 = {rowy[0], rowy[1], rowy[2]};
            else
            begin
               next_s4 = {filt_en ? avg : chroma, rowy[1], 12'h000};
               next_ph_out = ~ph_out;
               if (ph_out)
                  next_cr_prev = rowy[0];
               else
                  next_cb_prev = rowy[2];
            end
         end
      end
      if (v4 & ~busy)
      begin
         next_xfer_word = s4;
         next_xfer_req = ~xfer_req;
         next_word_count = word_count + 16'h1;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         s0 <= '0;
         s4 <= '0;
         v <= '0;
         v4 <= 1'b0;
         ph_in <= 1'b0;
         ph_out <= 1'b0;
         cb_hold <= '0;
         cr_hold <= '0;
         cb_prev <= '0;
         cr_prev <= '0;
         xfer_word <= '0;
         xfer_req <= 1'b0;
         word_count <= 16'h0;
      end
      else
      begin
         s0 <= next_s0;
         s4 <= next_s4;
         v <= next_v;
         v4 <= next_v4;
         ph_in <= next_ph_in;
         ph_out <= next_ph_out;
         cb_hold <= next_cb_hold;
         cr_hold <= next_cr_hold;
         cb_prev <= next_cb_prev;
         cr_prev <= next_cr_prev;
         xfer_word <= next_xfer_word;
         xfer_req <= next_xfer_req;
         word_count <= next_word_count;
      end
   end

   // ************************************************************
   // clock crossing
   // ************************************************************
   logic link_ack, next_link_ack, rst_s1, rst_s2, req_s1, req_s2;
   logic [3:0] cfg_s1, cfg_s2;

   always_ff @(posedge ref_clk)
   begin
      ack_s1 <= link_ack;
      ack_s2 <= ack_s1;
   end

   always_ff @(posedge link_clk)
   begin
      rst_s1 <= reset;
      rst_s2 <= rst_s1;
      req_s1 <= xfer_req;
      req_s2 <= req_s1;
      cfg_s1 <= {out_mode, out_width};
      cfg_s2 <= cfg_s1;
   end

   // ************************************************************
   // link output stage
   // ************************************************************
   csop_phase_type phase, next_phase;
   csop_word_type cur, next_cur;
   csop_out_type next_out_data;
   logic next_out_clk, next_out_de, ddr;
   logic [2:0] flush_cnt, next_flush_cnt;

   assign ddr = (cfg_s2[3:2] == OUT_DUAL8_DDR) || (cfg_s2[3:2] == OUT_422_12_DDR);

   always_comb
   begin
      next_phase = phase;
      next_cur = cur;
      next_link_ack = link_ack;
      next_flush_cnt = flush_cnt;
      next_out_data = out_data;
      next_out_clk = out_clk;
      next_out_de = out_de;
      unique case (phase)
         PH_RISE_SET:
         begin
            next_phase = PH_RISE_HOLD;
            // RULE12 - rising edge one cycle after data change
            next_out_clk = 1'b1;
         end
         PH_RISE_HOLD:
         begin
            next_phase = PH_FALL_SET;
            if (ddr)
               next_out_data = pack_out(cur, cfg_s2[3:2], cfg_s2[1:0], 1'b1);
         end
         PH_FALL_SET:
         begin
            next_phase = PH_FALL_HOLD;
            next_out_clk = 1'b0;
         end
         PH_FALL_HOLD:
         begin
            next_phase = PH_RISE_SET;
            next_out_de = 1'b0;
            if (req_s2 != link_ack)
            begin
               next_cur = xfer_word;
               next_link_ack = req_s2;
               // RULE13 - flush words leave enable low
               next_out_de = flush_cnt == FLUSH_WORDS;
               if (flush_cnt != FLUSH_WORDS)
                  next_flush_cnt = flush_cnt + 3'h1;
            end
            next_out_data = pack_out(next_cur, cfg_s2[3:2], cfg_s2[1:0], 1'b0);
         end
      endcase
   end

   always_ff @(posedge link_clk)
   begin
      if (rst_s2)
      begin
         phase <= PH_RISE_SET;
         cur <= '0;
         link_ack <= 1'b0;
         flush_cnt <= 3'h0;
         out_data <= '0;
         out_clk <= 1'b0;
         out_de <= 1'b0;
      end
      else
      begin
         phase <= next_phase;
         cur <= next_cur;
         link_ack <= next_link_ack;
         flush_cnt <= next_flush_cnt;
         out_data <= next_out_data;
         out_clk <= next_out_clk;
         out_de <= next_out_de;
      end
   end

endmodule

// ==== rtl/csop_pkg.sv ====
package csop_pkg;

   // ************************************************************
   // datapath widths
   // ************************************************************
   localparam int SAMPLE_W = 12;
   localparam int COEF_W = 13;
   localparam int FRAC_BITS = 12;
   localparam int SHIFT_W = 2;
   localparam int ROWS = 3;
   localparam int TERMS = 4;

   // ************************************************************
   // register map (byte addresses)
   // ************************************************************
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_COEF_BASE = 8'h10;
   localparam logic [7:0] REG_COEF_LAST = 8'h3C;

   // control fields
   localparam int CTRL_IN_FMT_LSB = 0;
   localparam int CTRL_IN_W_LSB = 2;
   localparam int CTRL_OUT_MODE_LSB = 4;
   localparam int CTRL_OUT_W_LSB = 6;
   localparam int CTRL_SHIFT_LSB = 8;
   localparam int CTRL_FILT_BIT = 10;
   localparam logic [31:0] CTRL_MASK = 32'h0000_07FF;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0500;
   localparam int STATUS_BUSY_BIT = 16;

   // unity gain is 2048/4096 scaled by two (shift of one)
   localparam logic [COEF_W-1:0] COEF_UNITY = 13'h0800;
   localparam logic [COEF_W-1:0] COEF_ZERO = 13'h0000;
   localparam logic [ROWS*TERMS-1:0][COEF_W-1:0] COEF_RESET = {
      COEF_ZERO, COEF_UNITY, COEF_ZERO, COEF_ZERO,
      COEF_ZERO, COEF_ZERO, COEF_UNITY, COEF_ZERO,
      COEF_ZERO, COEF_ZERO, COEF_ZERO, COEF_UNITY};

   // ************************************************************
   // format and mode codes
   // ************************************************************
   localparam logic [1:0] IN_RGB444 = 2'h0;
   localparam logic [1:0] IN_YCC444 = 2'h1;
   localparam logic [1:0] IN_YCC422 = 2'h2;
   localparam logic [1:0] WID_8 = 2'h0;
   localparam logic [1:0] WID_10 = 2'h1;
   localparam logic [1:0] WID_12 = 2'h2;
   localparam logic [1:0] OUT_444 = 2'h0;
   localparam logic [1:0] OUT_422 = 2'h1;
   localparam logic [1:0] OUT_DUAL8_DDR = 2'h2;
   localparam logic [1:0] OUT_422_12_DDR = 2'h3;

   localparam logic [2:0] FLUSH_WORDS = 3'h6;

   // ************************************************************
   // carriers
   // ************************************************************
   typedef struct packed {
      logic [SAMPLE_W-1:0] red;
      logic [SAMPLE_W-1:0] green;
      logic [SAMPLE_W-1:0] blue;
   } csop_pix_type;

   typedef struct packed {
      logic [SAMPLE_W-1:0] c0;
      logic [SAMPLE_W-1:0] c1;
      logic [SAMPLE_W-1:0] c2;
   } csop_word_type;

   typedef struct packed {
      logic [7:0] red;
      logic [7:0] green;
      logic [7:0] blue;
   } csop_out_type;

   typedef enum logic [1:0] {
      PH_RISE_SET,
      PH_RISE_HOLD,
      PH_FALL_SET,
      PH_FALL_HOLD
   } csop_phase_type;

endpackage

// ==== rtl/csop_matrix_row.sv ====
`timescale 1ns/100ps
module csop_matrix_row (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic advance,
   input wire csop_pkg::csop_pix_type pix,
   input wire logic [csop_pkg::TERMS-1:0][csop_pkg::COEF_W-1:0] coef,
   input wire logic [csop_pkg::SHIFT_W-1:0] shift,
   output logic [csop_pkg::SAMPLE_W-1:0] result
);
   import csop_pkg::*;

   logic signed [25:0] p0, p1, p2, next_p0, next_p1, next_p2;
   logic signed [31:0] sum, next_sum, raw;
   logic [SAMPLE_W-1:0] next_result;

   // ************************************************************
   // multiply, accumulate, scale, clip
   // ************************************************************
   // RULE4 - three weighted products
   assign raw = 32'(p0) + 32'(p1) + 32'(p2) + (32'($signed(coef[3])) <<< FRAC_BITS);

   always_comb
   begin
      next_p0 = p0;
      next_p1 = p1;
      next_p2 = p2;
      next_sum = sum;
      next_result = result;
      if (advance)
      begin
         // RULE8 - coefficients carry twelve fraction bits
         next_p0 = $signed(coef[0]) * $signed({1'b0, pix.red});
         next_p1 = $signed(coef[1]) * $signed({1'b0, pix.green});
         next_p2 = $signed(coef[2]) * $signed({1'b0, pix.blue});
         // RULE10 - shared power-of-two scale
         next_sum = raw <<< shift;
         // RULE15 - saturate to output range
         if (sum < 0)
            next_result = '0;
         else if (sum[30:24] != 7'h00)
            next_result = '1;
         else
            next_result = sum[23:12];
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         p0 <= '0;
         p1 <= '0;
         p2 <= '0;
         sum <= '0;
         result <= '0;
      end
      else
      begin
         p0 <= next_p0;
         p1 <= next_p1;
         p2 <= next_p2;
         sum <= next_sum;
         result <= next_result;
      end
   end

endmodule

// ==== tb/csop_output_path_checker.sv ====
`timescale 1ns/100ps
module csop_output_path_checker #(
   parameter int ADDR_W = 8
)(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic link_clk,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire csop_pkg::csop_pix_type in_pix,
   input wire logic in_valid,
   input wire logic in_ready,
   input wire csop_pkg::csop_out_type out_data,
   input wire logic out_clk,
   input wire logic out_de
);
   import csop_pkg::*;
   wire logic bus_req = avs_read | avs_write;
   // ******
   // register bus
   // ******
   chk_wait_first:
   assert property (@(posedge ref_clk) disable iff (reset) $rose(bus_req) |-> avs_waitrequest)
      else $error("new request got no wait state");
   chk_wait_single:
   assert property (@(posedge ref_clk) disable iff (reset)
      bus_req && avs_waitrequest |=> !avs_waitrequest) else $error("wait longer than one cycle");
   chk_idle_quiet:
   assert property (@(posedge ref_clk) disable iff (reset) !bus_req |-> !avs_waitrequest)
      else $error("wait raised while idle");
   chk_read_hold:
   assert property (@(posedge ref_clk) disable iff (reset) !avs_read |=> $stable(avs_readdata))
      else $error("read data changed without a read");
   // ******
   // output link
   // ******
   chk_clk_shape:
   assert property (@(posedge link_clk) disable iff (reset)
      $rose(out_clk) |=> out_clk ##1 !out_clk [*2] ##1 out_clk) else $error("bad out_clk shape");
   chk_rise_steady:
   assert property (@(posedge link_clk) disable iff (reset)
      $rose(out_clk) |-> $stable(out_data) && $stable(out_de)) else $error("data moved at rise");
   chk_fall_steady:
   assert property (@(posedge link_clk) disable iff (reset) $fell(out_clk) |-> $stable(out_data))
      else $error("data moved at fall");
   chk_data_mid:
   assert property (@(posedge link_clk) disable iff (reset)
      $changed(out_data) |-> out_clk == $past(out_clk)) else $error("data moved with clock");
   chk_de_align:
   assert property (@(posedge link_clk) disable iff (reset)
      $changed(out_de) |-> !out_clk && !$past(out_clk)) else $error("de moved mid period");
   chk_de_whole:
   assert property (@(posedge link_clk) disable iff (reset) $rose(out_de) |-> out_de [*4])
      else $error("de shorter than a period");
endmodule

bind csop_output_path csop_output_path_checker #(.ADDR_W(ADDR_W)) csop_output_path_checker_i (
   .ref_clk(ref_clk), .reset(reset), .link_clk(link_clk), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .in_pix(in_pix), .in_valid(in_valid),
   .in_ready(in_ready), .out_data(out_data), .out_clk(out_clk), .out_de(out_de));

// ==== tb/csop_sink_model.sv ====
`timescale 1ns/100ps
module csop_sink_model (
   input wire logic out_clk,
   input wire logic out_de,
   input wire csop_pkg::csop_out_type out_data
);
   import csop_pkg::*;
   csop_out_type rise_q[$];
   csop_out_type fall_q[$];
   // latch at rise and at fall, flush words dropped
   always @(posedge out_clk)
   begin
      if (out_de === 1'b1)
         rise_q.push_back(out_data);
   end
   always @(negedge out_clk)
   begin
      if (out_de === 1'b1)
         fall_q.push_back(out_data);
   end
endmodule

// ==== tb/test_color_space_output_path.sv ====
`timescale 1ns/100ps
module test_color_space_output_path;
   import csop_pkg::*;
   logic ref_clk = 1'b0;
   logic link_clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic [31:0] bus_rdata = 32'h0;
   logic avs_waitrequest, in_ready, out_clk, out_de;
   csop_pix_type in_pix = '0;
   logic in_valid = 1'b0;
   csop_out_type out_data;
   int miscompares = 0;
   int comparisons = 0;
   int cycles = 0;
   int cf[12];
   logic [23:0] exp_q[$];
   logic [35:0] px[2] = '{36'h400_800_200, 36'hF00_100_C00};

   initial
   begin
      forever #4 ref_clk = ~ref_clk;
   end
   initial
   begin
      #1.3;
      forever #3 link_clk = ~link_clk;
   end

   csop_output_path #(.ADDR_W(8)) csop_output_path_i (
      .ref_clk(ref_clk), .reset(reset), .link_clk(link_clk), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .in_pix(in_pix), .in_valid(in_valid), .in_ready(in_ready), .out_data(out_data),
      .out_clk(out_clk), .out_de(out_de));
   csop_sink_model csop_sink_model_i (.out_clk(out_clk), .out_de(out_de), .out_data(out_data));

   // ******
   // shared tasks
   // ******
   task report_and_stop;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   always @(posedge ref_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         miscompares++;
         report_and_stop;
      end
   end

   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      // hold the request until waitrequest is seen low at a rising edge
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0)
         @(posedge ref_clk);
      bus_rdata = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(what, bus_rdata, exp);
   endtask

   task send(input logic [35:0] p);
      @(posedge ref_clk);
      in_pix <= p;
      in_valid <= 1'b1;
      @(negedge ref_clk);
      while (in_ready !== 1'b1)
         @(negedge ref_clk);
   endtask

   task finish_words(input string what, input int skip, input logic ddr);
      @(posedge ref_clk);
      in_valid <= 1'b0;
      while (csop_sink_model_i.rise_q.size() < skip + exp_q.size())
         @(posedge ref_clk);
      repeat (60) @(posedge ref_clk);
      check(what, 32'(csop_sink_model_i.rise_q.size()), 32'(skip + exp_q.size()));
      foreach (exp_q[i])
      begin
         check(what, 32'(csop_sink_model_i.rise_q[skip + i]),
            ddr ? {20'h0, exp_q[i][23:12]} : 32'(exp_q[i]));
         check(what, 32'(csop_sink_model_i.fall_q[skip + i]),
            ddr ? {20'h0, exp_q[i][11:0]} : 32'(exp_q[i]));
      end
      exp_q.delete();
      csop_sink_model_i.rise_q.delete();
      csop_sink_model_i.fall_q.delete();
   endtask

   task load_coefs;
      for (int i = 0; i < 12; i++)
         bus(1'b1, REG_COEF_BASE + 8'(4 * i), {19'h0, 13'(cf[i])});
   endtask

   function automatic logic [7:0] mix(int row, int sh, logic [35:0] p);
      int acc;
      acc = cf[row*4] * int'(p[35:24]) + cf[row*4+1] * int'(p[23:12]);
      acc = (acc + cf[row*4+2] * int'(p[11:0]) + cf[row*4+3] * 4096) * (1 << sh) / 4096;
      acc = (acc < 0) ? 0 : (acc > 4095) ? 4095 : acc;
      return 8'(acc >> 4);
   endfunction

   // ******
   // scenarios
   // ******
   task t_registers;
      rdchk("ctrl reset", REG_CTRL, 32'h500);
      for (int i = 0; i < 12; i++)
         rdchk("coef reset", REG_COEF_BASE + 8'(4 * i), (i % 5 == 0) ? 32'h800 : 32'h0);
      bus(1'b1, REG_COEF_BASE, 32'hFFFF_FFFF);
      rdchk("coef width", REG_COEF_BASE, 32'h1FFF);
      bus(1'b1, REG_COEF_BASE, 32'h800);
      bus(1'b1, 8'h80, 32'hFFFF_FFFF);
      rdchk("unmapped", 8'h80, 32'h0);
      bus(1'b1, REG_CTRL, 32'hFFFF_FFFF);
      rdchk("ctrl mask", REG_CTRL, CTRL_MASK);
      $display("test registers done");
   endtask

   task t_flush;
      bus(1'b1, REG_CTRL, 32'h100);
      // first six words never reach the sink
      for (int i = 0; i < 10; i++)
      begin
         send({8'(16 + i), 4'h0, 8'(64 + i), 4'h0, 8'(128 + i), 4'h0});
         if (i > 5)
            exp_q.push_back({8'(16 + i), 8'(64 + i), 8'(128 + i)});
      end
      finish_words("flush", 0, 1'b0);
      rdchk("status", REG_STATUS, 32'hA);
      $display("test flush done");
   endtask

   task t_matrix(input int sh);
      bus(1'b1, REG_CTRL, {22'h0, 2'(sh), 8'h00});
      cf = '{2048, 1024, 0, 16, -2048, 2048, 0, 0, 0, 0, 2047, 2047};
      load_coefs;
      foreach (px[p])
      begin
         send(px[p]);
         exp_q.push_back({mix(0, sh, px[p]), mix(1, sh, px[p]), mix(2, sh, px[p])});
      end
      finish_words("matrix", 0, 1'b0);
      $display("test matrix shift %0d done", sh);
   endtask

   task t_chroma(input logic ddr);
      // DDR run puts chroma on rise, luma on fall
      bus(1'b1, REG_CTRL, {21'h0, 1'b1, 2'h1, WID_12, ddr ? OUT_422_12_DDR : OUT_422, WID_12,
         IN_YCC422});
      cf = '{2048, 0, 0, 0, 0, 2048, 0, 0, 0, 0, 2048, 0};
      load_coefs;
      for (int i = 0; i < 6; i++)
      begin
         send(36'hA5C_3C7_000);
         if (i > 1)
            exp_q.push_back(24'hA5C_3C7);
      end
      finish_words("chroma", 2, ddr);
      $display("test chroma ddr %0d done", ddr);
   endtask

   initial
   begin
      repeat (6) @(posedge ref_clk);
      reset <= 1'b0;
      t_registers;
      t_flush;
      t_matrix(1);
      t_matrix(2);
      t_chroma(1'b0);
      t_chroma(1'b1);
      report_and_stop;
   end
endmodule
